// file: design/uic_ctrl.sv
/*
  Interrupt enable, interrupt identification and FIFO control of one
  serial port, reached as an Avalon-MM slave with waitrequest.
  Assumes the receiver, transmitter, line and modem status logic sit on the
  same clock and deliver one-cycle event pulses and the receive fill count.
*/
// Function
// - Enable bit 0 allows received data and, in FIFO mode, character timeout.
// - Enable bit 1 allows the transmitter holding register empty interrupt.
// - Enable bit 2 allows the line status error interrupt.
// - Enable bit 3 allows the modem status change interrupt.
// - Upper four enable bits always read zero.
// - All enables clear means no interrupt and an idle identification.
// - Index 2 writes FIFO control and reads identification, regardless of divisor select.
// - FIFO control bit 0 enables FIFOs; zero disables and flushes both.
// - Other FIFO control bits take effect only with bit 0 set.
// - FIFO control bit 1 flushes the receive FIFO, then self-clears.
// - FIFO control bit 2 flushes the transmit FIFO, then self-clears.
// - FIFO control bit 3 has no effect.
// - FIFO control bits 7:6 pick receive trigger of 1, 4, 8, 14 bytes.
// - Priority: line status, received data or timeout, transmit empty, modem.
// - Identification value is frozen for the whole read access.
// - Identification bit 0 is zero when an enabled interrupt is pending.
// - Identification bits 2:1 encode the highest pending source.
// - Identification bit 3 flags character timeout, only in FIFO mode.
// - Identification bits 5:4 read zero; 7:6 read one in FIFO mode.
// - Last FIFO control value is readable through a shadow register.
// - Divisor select moves indices 0 and 1 to the divisor bytes.
`timescale 1ns/1ps
`default_nettype none
module uic_ctrl
  import uic_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_arst_n,
  input  wire logic        i_ce,
  input  wire logic [7:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  input  wire logic [3:0]  i_avs_byteenable,
  output logic      [31:0] o_avs_readdata,
  output logic             o_avs_waitrequest,
  input  wire uic_evt_t    i_evt,
  input  wire logic [4:0]  i_rx_count,
  input  wire logic [7:0]  i_rx_data,
  input  wire logic [7:0]  i_line_status,
  input  wire logic [7:0]  i_modem_status,
  output logic             o_irq,
  output logic             o_fifo_enable,
  output logic             o_rx_flush,
  output logic             o_tx_flush,
  output logic             o_rx_buf_read,
  output logic             o_tx_hold_write,
  output logic      [7:0]  o_tx_data,
  output logic             o_line_status_read,
  output logic             o_modem_status_read,
  output logic      [7:0]  o_line_control,
  output logic      [15:0] o_divisor
);

  uic_state_t s_r;
  uic_state_t s_nxt;

  logic [5:0] idx;
  logic       req;
  logic       start;
  logic       done;
  logic       wr;
  logic       rd_done;
  logic       dls;
  logic       rx_level;
  logic       to_pend;
  logic       en_ls;
  logic       en_rx;
  logic       en_to;
  logic       en_tx;
  logic       en_ms;
  logic [7:0] id_live;
  logic [7:0] rd_mux;
  logic       buf_rd;
  logic       buf_wr;

  function automatic logic [4:0] trig_bytes(input logic [1:0] sel);
    unique case (sel)
      2'h0: trig_bytes = UIC_TRIG_0;
      2'h1: trig_bytes = UIC_TRIG_1;
      2'h2: trig_bytes = UIC_TRIG_2;
      2'h3: trig_bytes = UIC_TRIG_3;
    endcase
  endfunction

  // Index decode also gated by divisor select where the index is shared.
  function automatic logic hit(input logic [5:0] a, input logic [5:0] want,
                               input logic sel, input logic need_data);
    hit = (a == want) && (sel == need_data);
  endfunction

  assign idx   = i_avs_address[7:2];
  assign dls   = s_r.lcr[UIC_LCR_DLS];
  assign req   = i_avs_read | i_avs_write;
  assign start = i_ce & req & ~s_r.ack;
  assign done  = i_ce & req & s_r.ack;
  assign wr    = done & i_avs_write & i_avs_byteenable[0];
  assign rd_done = done & i_avs_read;

  // A read of the receive buffer or a write of the holding register.
  assign buf_rd = rd_done & hit(idx, UIC_IDX_BUF, dls, 1'b0);
  assign buf_wr = wr & hit(idx, UIC_IDX_BUF, dls, 1'b0);

  // Received data is a level: it falls by itself once the FIFO drains below the trigger.
  assign rx_level = s_r.fifo_en ? (i_rx_count >= trig_bytes(s_r.trig)) : (i_rx_count != 5'h00);
  assign to_pend  = s_r.fifo_en && (s_r.to_cnt == UIC_TO_CHARS) && (i_rx_count != 5'h00);

  assign en_ls = s_r.pend_ls   & s_r.interrupt_enable[UIC_IER_LS];
  assign en_rx = rx_level      & s_r.interrupt_enable[UIC_IER_RX];
  assign en_to = to_pend       & s_r.interrupt_enable[UIC_IER_RX];
  assign en_tx = s_r.pend_thre & s_r.interrupt_enable[UIC_IER_TX];
  assign en_ms = s_r.pend_ms   & s_r.interrupt_enable[UIC_IER_MS];

  // Disabled sources never reach the code, so all enables low reads as idle.
  always_comb begin
    id_live[7:6] = s_r.fifo_en ? UIC_ID_FIFO : 2'h0;
    id_live[5:4] = 2'h0;
    if (en_ls) begin
      id_live[3:0] = UIC_ID_LS;
    end else if (en_to) begin
      id_live[3:0] = UIC_ID_TO;
    end else if (en_rx) begin
      id_live[3:0] = UIC_ID_RX;
    end else if (en_tx) begin
      id_live[3:0] = UIC_ID_TX;
    end else if (en_ms) begin
      id_live[3:0] = UIC_ID_MS;
    end else begin
      id_live[3:0] = UIC_ID_NONE;
    end
  end

  always_comb begin
    rd_mux = 8'h00;
    unique case (idx)
      UIC_IDX_BUF: begin
        rd_mux = dls ? s_r.div_lo : i_rx_data;
      end
      UIC_IDX_IER: begin
        rd_mux = dls ? s_r.div_hi : {4'h0, s_r.interrupt_enable};
      end
      UIC_IDX_FIFO: begin
        rd_mux = id_live;
      end
      UIC_IDX_LCR: begin
        rd_mux = s_r.lcr;
      end
      UIC_IDX_LSR: begin
        rd_mux = i_line_status;
      end
      UIC_IDX_MSR: begin
        rd_mux = i_modem_status;
      end
      UIC_IDX_SHADOW: begin
        rd_mux = s_r.fcr_shadow;
      end
      default: begin
        rd_mux = 8'h00;
      end
    endcase
  end

  always_comb begin
    s_nxt = s_r;
    s_nxt.rx_flush = 1'b0;
    s_nxt.tx_flush = 1'b0;
    s_nxt.rx_pop   = 1'b0;
    s_nxt.tx_push  = 1'b0;
    s_nxt.ls_read  = 1'b0;
    s_nxt.ms_read  = 1'b0;
    s_nxt.ack      = start;

    // Value and source are captured at the first edge and held until the access ends.
    if (start && i_avs_read) begin
      s_nxt.rdata = rd_mux;
      if (idx == UIC_IDX_FIFO) begin
        s_nxt.id_snap = id_live[3:0];
      end
    end

    if (wr) begin
      unique case (idx)
        UIC_IDX_BUF: begin
          if (dls) begin
            s_nxt.div_lo = i_avs_writedata[7:0];
          end else begin
            s_nxt.tx_data = i_avs_writedata[7:0];
            s_nxt.tx_push = 1'b1;
          end
        end
        UIC_IDX_IER: begin
          if (dls) begin
            s_nxt.div_hi = i_avs_writedata[7:0];
          end else begin
            s_nxt.interrupt_enable = i_avs_writedata[3:0];
          end
        end
        UIC_IDX_FIFO: begin
          s_nxt.fcr_shadow = i_avs_writedata[7:0];
          s_nxt.fifo_en    = i_avs_writedata[UIC_FCR_EN];
          if (!i_avs_writedata[UIC_FCR_EN] || !s_r.fifo_en) begin
            // Any change of mode discards what both FIFOs held.
            s_nxt.rx_flush = s_r.fifo_en | i_avs_writedata[UIC_FCR_EN] | ~i_avs_writedata[UIC_FCR_EN];
            s_nxt.tx_flush = s_r.fifo_en | i_avs_writedata[UIC_FCR_EN] | ~i_avs_writedata[UIC_FCR_EN];
          end
          // Bit 3 and the reserved bits steer nothing.
          if (i_avs_writedata[UIC_FCR_EN]) begin
            s_nxt.trig = i_avs_writedata[UIC_FCR_TRIG_HI:UIC_FCR_TRIG_LO];
            if (i_avs_writedata[UIC_FCR_RXCLR]) begin
              s_nxt.rx_flush = 1'b1;
            end
            if (i_avs_writedata[UIC_FCR_TXCLR]) begin
              s_nxt.tx_flush = 1'b1;
            end
          end
        end
        UIC_IDX_LCR: begin
          s_nxt.lcr = i_avs_writedata[7:0];
        end
        default: begin
        end
      endcase
    end

    if (buf_rd) begin
      s_nxt.rx_pop = 1'b1;
    end
    if (rd_done && idx == UIC_IDX_LSR) begin
      s_nxt.ls_read = 1'b1;
    end
    if (rd_done && idx == UIC_IDX_MSR) begin
      s_nxt.ms_read = 1'b1;
    end

    // A new event in the clearing cycle wins over the clear.
    s_nxt.pend_ls = i_evt.line_err |
                    (s_r.pend_ls & ~(rd_done && idx == UIC_IDX_LSR));
    s_nxt.pend_ms = i_evt.modem_chg |
                    (s_r.pend_ms & ~(rd_done && idx == UIC_IDX_MSR));
    s_nxt.pend_thre = i_evt.thr_empty |
                      (s_r.pend_thre & ~buf_wr &
                       ~(rd_done && idx == UIC_IDX_FIFO && s_r.id_snap == UIC_ID_TX));

    // Silence counter: restarts on any push or pop, so a buffer read clears the timeout.
    if (!s_r.fifo_en || i_rx_count == 5'h00 || i_evt.rx_push || buf_rd) begin
      s_nxt.to_cnt = 3'h0;
    end else if (i_evt.char_tick && s_r.to_cnt != UIC_TO_CHARS) begin
      s_nxt.to_cnt = s_r.to_cnt + 3'h1;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      s_r <= UIC_STATE_RST;
    end else if (i_ce) begin
      s_r <= s_nxt;
    end
  end

  // Waitrequest is combinational so each access costs exactly one wait cycle while the clock enable stays high.
  // A low clock enable keeps it high, so the master never sees a completion that was not taken.
  assign o_avs_waitrequest   = req & ~(s_r.ack & i_ce);
  assign o_avs_readdata      = {24'h000000, s_r.rdata};
  assign o_irq               = en_ls | en_rx | en_to | en_tx | en_ms;
  assign o_fifo_enable       = s_r.fifo_en;
  assign o_rx_flush          = s_r.rx_flush;
  assign o_tx_flush          = s_r.tx_flush;
  assign o_rx_buf_read       = s_r.rx_pop;
  assign o_tx_hold_write     = s_r.tx_push;
  assign o_tx_data           = s_r.tx_data;
  assign o_line_status_read  = s_r.ls_read;
  assign o_modem_status_read = s_r.ms_read;
  assign o_line_control      = s_r.lcr;
  assign o_divisor           = {s_r.div_hi, s_r.div_lo};

endmodule // uic_ctrl
`default_nettype wire

// file: design/uic_pkg.sv
/*
  Package for the serial port interrupt and FIFO control block: register
  indices, field positions, reset values, codes and carrier structs.
  Assumes byte-wide registers, one per aligned 32-bit bus word.
*/
`default_nettype none
package uic_pkg;

  // Register indices; the byte address is four times the index.
  localparam logic [5:0] UIC_IDX_BUF    = 6'h00;
  localparam logic [5:0] UIC_IDX_IER    = 6'h01;
  localparam logic [5:0] UIC_IDX_FIFO   = 6'h02;
  localparam logic [5:0] UIC_IDX_LCR    = 6'h03;
  localparam logic [5:0] UIC_IDX_LSR    = 6'h05;
  localparam logic [5:0] UIC_IDX_MSR    = 6'h06;
  localparam logic [5:0] UIC_IDX_SHADOW = 6'h20;

  // Interrupt enable fields.
  localparam int UIC_IER_RX  = 0;
  localparam int UIC_IER_TX  = 1;
  localparam int UIC_IER_LS  = 2;
  localparam int UIC_IER_MS  = 3;

  // FIFO control fields.
  localparam int UIC_FCR_EN      = 0;
  localparam int UIC_FCR_RXCLR   = 1;
  localparam int UIC_FCR_TXCLR   = 2;
  localparam int UIC_FCR_TRIG_LO = 6;
  localparam int UIC_FCR_TRIG_HI = 7;

  // Line control divisor latch select bit.
  localparam int UIC_LCR_DLS = 7;

  // Identification codes in bits 3:0; the FIFO mode marker goes in bits 7:6.
  localparam logic [3:0] UIC_ID_NONE = 4'h1;
  localparam logic [3:0] UIC_ID_LS   = 4'h6;
  localparam logic [3:0] UIC_ID_RX   = 4'h4;
  localparam logic [3:0] UIC_ID_TO   = 4'hC;
  localparam logic [3:0] UIC_ID_TX   = 4'h2;
  localparam logic [3:0] UIC_ID_MS   = 4'h0;
  localparam logic [1:0] UIC_ID_FIFO = 2'h3;

  // Receive trigger thresholds in bytes.
  localparam logic [4:0] UIC_TRIG_0 = 5'h01;
  localparam logic [4:0] UIC_TRIG_1 = 5'h04;
  localparam logic [4:0] UIC_TRIG_2 = 5'h08;
  localparam logic [4:0] UIC_TRIG_3 = 5'h0E;

  // Character times of silence before a receive timeout.
  localparam logic [2:0] UIC_TO_CHARS = 3'h4;

  typedef struct packed {
    logic rx_push;
    logic thr_empty;
    logic line_err;
    logic modem_chg;
    logic char_tick;
  } uic_evt_t;

  typedef struct packed {
    logic [3:0] interrupt_enable;
    logic       fifo_en;
    logic [1:0] trig;
    logic [7:0] fcr_shadow;
    logic [7:0] lcr;
    logic [7:0] div_lo;
    logic [7:0] div_hi;
    logic       pend_ls;
    logic       pend_thre;
    logic       pend_ms;
    logic [2:0] to_cnt;
    logic       ack;
    logic [7:0] rdata;
    logic [3:0] id_snap;
    logic       rx_flush;
    logic       tx_flush;
    logic       rx_pop;
    logic       tx_push;
    logic       ls_read;
    logic       ms_read;
    logic [7:0] tx_data;
  } uic_state_t;

  localparam uic_state_t UIC_STATE_RST = '0;

endpackage
`default_nettype wire

// file: tb/uic_ctrl_sva.sv
/*
  Checker for uic_ctrl: bus wait, readback, flush and interrupt relations.
  Assumes the bind below and one clock.
*/
`timescale 1ns/1ps
`default_nettype none
module uic_ctrl_sva
  import uic_pkg::*;
(
  input wire logic        i_clk,
  input wire logic        i_arst_n,
  input wire logic        i_ce,
  input wire logic [7:0]  i_avs_address,
  input wire logic        i_avs_read,
  input wire logic        i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0]  i_avs_byteenable,
  input wire logic [31:0] o_avs_readdata,
  input wire logic        o_avs_waitrequest,
  input wire uic_evt_t    i_evt,
  input wire logic        o_irq,
  input wire logic        o_fifo_enable,
  input wire logic        o_rx_flush,
  input wire logic        o_tx_flush,
  input wire logic [7:0]  o_line_control
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  logic       done, wr1, wr2, rd1, rd2;
  logic [3:0] ier_r;
  assign done = (i_avs_read | i_avs_write) & ~o_avs_waitrequest & i_ce;
  assign wr1 = done & i_avs_write & i_avs_byteenable[0] & (i_avs_address[7:2] == UIC_IDX_IER) & ~o_line_control[7];
  assign wr2 = done & i_avs_write & i_avs_byteenable[0] & (i_avs_address[7:2] == UIC_IDX_FIFO);
  assign rd1 = done & i_avs_read & (i_avs_address[7:2] == UIC_IDX_IER) & ~o_line_control[7];
  assign rd2 = done & i_avs_read & (i_avs_address[7:2] == UIC_IDX_FIFO);
  // Own copy of the enables, so no probe into the body is needed.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) ier_r <= 4'h0;
    else if (wr1) ier_r <= i_avs_writedata[3:0];
  end
  one_wait_a: assert property ((i_avs_read | i_avs_write) && o_avs_waitrequest && i_ce
    |=> !o_avs_waitrequest || !(i_avs_read | i_avs_write) || !i_ce) else $error("wait not one cycle");
  ier_upper_a: assert property (rd1 |-> o_avs_readdata[7:4] == 4'h0) else $error("enable upper bits set");
  iir_fixed_a: assert property (rd2 |-> o_avs_readdata[5:4] == 2'h0
    && o_avs_readdata[7:6] == {2{o_fifo_enable}}) else $error("ident fixed bits wrong");
  iir_pend_a: assert property (rd2 |-> o_avs_readdata[0] == !$past(o_irq)) else $error("ident bit0 wrong");
  fifo_off_a: assert property (wr2 && !i_avs_writedata[0] |=> o_rx_flush && o_tx_flush && !o_fifo_enable)
    else $error("fifo disable wrong");
  rx_flush_a: assert property (wr2 && i_avs_writedata[1:0] == 2'h3 |=> o_rx_flush) else $error("no rx flush");
  tx_flush_a: assert property (wr2 && i_avs_writedata[2] && i_avs_writedata[0] |=> o_tx_flush)
    else $error("no tx flush");
  flush_once_a: assert property (o_rx_flush |=> !o_rx_flush) else $error("rx flush stuck");
  irq_off_a: assert property (ier_r == 4'h0 |-> !o_irq) else $error("irq with enables off");
  ls_irq_a: assert property (i_ce && !wr1 && ier_r[UIC_IER_LS] && i_evt.line_err |=> o_irq)
    else $error("line irq missing");
  cover property (wr2);
  cover property (rd2 && o_avs_readdata[3:0] == UIC_ID_TO);
  cover property (rd2 && o_avs_readdata[3:0] == UIC_ID_LS);
endmodule // uic_ctrl_sva
bind uic_ctrl uic_ctrl_sva u_sva (.i_clk, .i_arst_n, .i_ce, .i_avs_address, .i_avs_read, .i_avs_write,
  .i_avs_writedata, .i_avs_byteenable, .o_avs_readdata, .o_avs_waitrequest, .i_evt, .o_irq, .o_fifo_enable,
  .o_rx_flush, .o_tx_flush, .o_line_control);
`default_nettype wire

// file: tb/uic_ctrl_tb.sv
/*
  Self-checking bench for uic_ctrl: enables, priority, FIFO control, timeout.
  Assumes the checker binds itself; bus has one byte a word.
*/
`timescale 1ns/1ps
`default_nettype none
module uic_ctrl_tb
  import uic_pkg::*;
;
  logic        i_clk = 0, i_arst_n = 0, i_avs_read = 0, i_avs_write = 0;
  logic [7:0]  i_avs_address = '0, i_line_status = '0, d, rd;
  logic [31:0] i_avs_writedata = '0, o_avs_readdata;
  logic [4:0]  i_rx_count = '0;
  uic_evt_t    i_evt = '0;
  logic        o_avs_waitrequest, o_irq, o_fifo_enable, o_rx_flush, o_tx_flush, o_rx_buf_read;
  logic        o_tx_hold_write, o_line_status_read, o_modem_status_read, i_ce = 1'b1;
  logic [7:0]  o_tx_data, o_line_control;
  logic [15:0] o_divisor;
  logic [3:0]  i_avs_byteenable = 4'hF;
  int          n_mismatch = 0, total_checks = 0, seed = 32'h6E47;
  uic_ctrl DUT (.i_clk, .i_arst_n, .i_ce, .i_avs_address, .i_avs_read, .i_avs_write, .i_avs_writedata,
    .i_avs_byteenable, .o_avs_readdata, .o_avs_waitrequest, .i_evt, .i_rx_count, .i_rx_data(8'hA5),
    .i_line_status, .i_modem_status(8'h3C), .o_irq, .o_fifo_enable, .o_rx_flush, .o_tx_flush, .o_rx_buf_read,
    .o_tx_hold_write, .o_tx_data, .o_line_status_read, .o_modem_status_read, .o_line_control,
    .o_divisor);
  always #2.5 i_clk = ~i_clk;
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Holds the request until waitrequest is seen low; only the watchdog ends a hang.
  task automatic acc(input logic w, input logic [5:0] a, input logic [7:0] v);
    @(posedge i_clk);
    i_avs_address <= {a, 2'h0};
    i_avs_writedata <= {24'h0, v};
    i_avs_write <= w;
    i_avs_read <= ~w;
    do begin
      @(posedge i_clk);
    end while (o_avs_waitrequest !== 1'b0);
    rd = o_avs_readdata[7:0];
    i_avs_write <= 1'b0;
    i_avs_read <= 1'b0;
  endtask
  task automatic rc(input string nm, input logic [5:0] a, input logic [7:0] e);
    acc(1'b0, a, 8'h00);
    chk(nm, e, rd);
  endtask
  task automatic ev(input logic [4:0] e);
    @(posedge i_clk);
    i_evt <= uic_evt_t'(e);
    @(posedge i_clk);
    i_evt <= '0;
  endtask
  function automatic logic [4:0] trig(input int t);
    return t == 0 ? 5'h01 : t == 1 ? 5'h04 : t == 2 ? 5'h08 : 5'h0E;
  endfunction
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    #20000;
    n_mismatch++;
    tally_and_finish();
  end
  initial begin
    repeat (4) @(posedge i_clk);
    i_arst_n <= 1'b1;
    rc("ier", 6'h01, 8'h00);
    rc("iir", 6'h02, 8'h01);
    acc(1'b1, 6'h03, 8'h00);
    repeat (8) begin
      d = 8'($random(seed));
      acc(1'b1, 6'h01, d);
      rc("ier", 6'h01, {4'h0, d[3:0]});
    end
    $display("test enables done");
    acc(1'b1, 6'h01, 8'h00);
    i_rx_count <= 5'h01;
    i_line_status <= d;
    ev(5'b01110);
    @(posedge i_clk);
    chk("irq", 8'h00, {7'h0, o_irq});
    rc("iir", 6'h02, 8'h01);
    acc(1'b1, 6'h01, 8'hFF);
    rc("iir", 6'h02, 8'h06);
    ev(5'b00100);
    rc("lsr", 6'h05, d);
    @(posedge i_clk);
    chk("lsr read", 8'h01, {7'h0, o_line_status_read});
    rc("iir", 6'h02, 8'h04);
    i_rx_count <= 5'h00;
    rc("iir", 6'h02, 8'h02);
    rc("iir", 6'h02, 8'h00);
    rc("msr", 6'h06, 8'h3C);
    @(posedge i_clk);
    chk("msr read", 8'h01, {7'h0, o_modem_status_read});
    rc("iir", 6'h02, 8'h01);
    ev(5'b01000);
    @(posedge i_clk);
    chk("irq", 8'h01, {7'h0, o_irq});
    acc(1'b1, 6'h00, d);
    @(posedge i_clk);
    chk("hold write", 8'h01, {7'h0, o_tx_hold_write});
    chk("tx data", d, o_tx_data);
    rc("iir", 6'h02, 8'h01);
    $display("test priority done");
    i_ce <= 1'b0;
    fork
      acc(1'b1, 6'h01, 8'h01);
      begin
        repeat (4) @(posedge i_clk);
        chk("ce wait", 8'h01, {7'h0, o_avs_waitrequest});
        i_ce <= 1'b1;
      end
    join
    i_avs_byteenable <= 4'hE;
    acc(1'b1, 6'h01, 8'h0F);
    i_avs_byteenable <= 4'hF;
    rc("ier", 6'h01, 8'h01);
    for (int t = 0; t < 4; t++) begin
      acc(1'b1, 6'h02, {t[1:0], 6'h01});
      rc("shadow", 6'h20, {t[1:0], 6'h01});
      i_rx_count <= trig(t) - 5'h01;
      rc("iir", 6'h02, 8'hC1);
      i_rx_count <= trig(t);
      rc("iir", 6'h02, 8'hC4);
    end
    $display("test trigger done");
    i_rx_count <= 5'h02;
    repeat (3) ev(5'b00001);
    rc("iir", 6'h02, 8'hC1);
    ev(5'b00001);
    rc("iir", 6'h02, 8'hCC);
    acc(1'b0, 6'h00, 8'h00);
    @(posedge i_clk);
    chk("bufrd", 8'h01, {7'h0, o_rx_buf_read});
    rc("iir", 6'h02, 8'hC1);
    $display("test timeout done");
    acc(1'b1, 6'h02, 8'h07);
    @(posedge i_clk);
    chk("flush", 8'h03, {6'h0, o_rx_flush, o_tx_flush});
    acc(1'b1, 6'h03, 8'h80);
    acc(1'b1, 6'h02, 8'h00);
    @(posedge i_clk);
    chk("off", 8'h03, {5'h0, o_fifo_enable, o_rx_flush, o_tx_flush});
    rc("iir", 6'h02, 8'h04);
    $display("test fifo control done");
    chk("lcr", 8'h80, o_line_control);
    d = 8'($random(seed));
    acc(1'b1, 6'h00, d);
    acc(1'b1, 6'h01, ~d);
    rc("div lo", 6'h00, d);
    rc("div hi", 6'h01, ~d);
    chk("divisor", ~d, o_divisor[15:8]);
    $display("test divisor done");
    tally_and_finish();
  end
endmodule // uic_ctrl_tb
`default_nettype wire
